/* core/boot_reset_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - an external reset held low for at least 8 clocks resets core and peripherals together.
// - the reset indication output stays low for 1024 clocks after the reset source releases.
// - select 00 with crystal pin 0 runs from the external oscillator with the PLL off.
// - select 00 with crystal pin 1 runs from the on-chip oscillator with the PLL off.
// - select 01 runs from the crystal with the PLL off, crystal pin ignored.
// - select 10 with crystal pin 0 runs the PLL from the external oscillator.
// - select 10 with crystal pin 1 runs the PLL from the on-chip oscillator.
// - select 11 runs the PLL from the crystal, crystal pin ignored.
// - when the upper select bit is 1 the crystal pin stays an input after reset; it is sampled as a strap when the lower select bit is 0.
// - the boot clock configuration comes from the two select pins and, when the lower select bit is 0, the crystal pin.
// - flash-boot strap asserted with test negated at reset exit enters flash programming mode.
// - the system clock output mirrors the internal system clock.
// - the clock source pin feeds the clock unless the on-chip oscillator is used.
module boot_reset_ctrl
  import boot_cfg_pkg::*;
#(
  parameter int MIN_ASSERT_CYCLES = RESET_MIN_CYCLES,
  parameter int HOLD_CYCLES = RESET_OUT_HOLD_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic EXTERNAL_RESET_INPUT_B,
  input wire logic [1:0] CLOCK_BOOT_SELECT,
  input wire logic CRYSTAL_PIN_IN,
  input wire logic FLASH_BOOT_STRAP_B,
  input wire logic TEST_PIN,
  input wire logic CLK_INTERNAL,
  output logic CRYSTAL_PIN_OUT,
  output logic CRYSTAL_PIN_OE_B,
  output logic RESET_INDICATION_OUTPUT_B,
  output logic SYSTEM_RESET_B,
  output logic PLL_ENABLE,
  output logic [1:0] CLOCK_SOURCE,
  output logic CLOCK_SOURCE_PIN_EN,
  output logic FLASH_PROG_MODE,
  output logic SYSTEM_CLOCK_OUTPUT
);

  // ==========================================================
  // external reset qualification
  logic [RST_CNT_W-1:0] low_cnt_q;
  logic [RST_CNT_W-1:0] low_cnt_d;
  logic ext_rst_q;
  logic ext_rst_d;

  always_comb
  begin
    low_cnt_d = low_cnt_q;
    ext_rst_d = ext_rst_q;
    if (EXTERNAL_RESET_INPUT_B)
    begin
      low_cnt_d = '0;
      ext_rst_d = 1'b0;
    end
    else if (low_cnt_q == RST_CNT_W'(MIN_ASSERT_CYCLES - 1))
    begin
      ext_rst_d = 1'b1;
    end
    else
    begin
      low_cnt_d = low_cnt_q + RST_CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      low_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= low_cnt_d;
      ext_rst_q <= ext_rst_d;
    end
  end

  // ==========================================================
  // reset output stretch
  logic stretch_low;

  reset_stretch #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) reset_stretch_inst (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .src_active(ext_rst_q),
    .out_low(stretch_low)
  );

  // ==========================================================
  // reset indication and core reset
  logic in_reset_q;
  logic in_reset_d;
  logic rst_out_b_q;
  logic rst_out_b_d;
  logic sys_rst_b_q;
  logic sys_rst_b_d;

  always_comb
  begin
    // straps stay open while the stretcher holds reset
    in_reset_d = stretch_low;
    rst_out_b_d = !stretch_low;
    sys_rst_b_d = !ext_rst_q && !stretch_low;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      in_reset_q <= 1'b1;
      rst_out_b_q <= 1'b0;
      sys_rst_b_q <= 1'b0;
    end
    else
    begin
      in_reset_q <= in_reset_d;
      rst_out_b_q <= rst_out_b_d;
      sys_rst_b_q <= sys_rst_b_d;
    end
  end

  // ==========================================================
  // strap capture and clock mode decode
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic crystal_pin_q;
  logic crystal_pin_d;
  logic flash_q;
  logic flash_d;
  logic pll_d;
  logic [1:0] src_d;
  logic pll_q;
  logic [1:0] src_q;
  logic clock_source_pin_en_d;
  logic clock_source_pin_en_q;
  logic crystal_pin_oe_b_q;
  logic crystal_pin_oe_b_d;
  logic crystal_pin_out_q;
  logic crystal_pin_out_d;

  always_comb
  begin
    sel_d = sel_q;
    crystal_pin_d = crystal_pin_q;
    flash_d = flash_q;
    // capture once as reset releases, then hold
    if (in_reset_q && !stretch_low)
    begin
      sel_d = CLOCK_BOOT_SELECT;
      crystal_pin_d = CRYSTAL_PIN_IN;
      flash_d = !FLASH_BOOT_STRAP_B && !TEST_PIN;
    end
    pll_d = PLL_EN_RESET;
    src_d = CLK_SRC_RESET;
    unique case (sel_d)
      CLKSEL_DIRECT:
      begin
        src_d = crystal_pin_d ? SRC_ON_CHIP : SRC_EXT_OSC;
      end
      CLKSEL_CRYSTAL_PIN:
      begin
        src_d = SRC_CRYSTAL;
      end
      CLKSEL_PLL:
      begin
        pll_d = 1'b1;
        src_d = crystal_pin_d ? SRC_ON_CHIP : SRC_EXT_OSC;
      end
      CLKSEL_PLL_CRYSTAL_PIN:
      begin
        pll_d = 1'b1;
        src_d = SRC_CRYSTAL;
      end
    endcase
    clock_source_pin_en_d = (src_d != SRC_ON_CHIP);
    // pin released through reset so the strap level can be read
    if (stretch_low)
    begin
      crystal_pin_oe_b_d = 1'b1;
    end
    else
    begin
      // afterwards an input only while upper select bit is set
      crystal_pin_oe_b_d = sel_d[CLKSEL_PLL_BIT];
    end
    // oscillator drive is analog, digital level stays low
    crystal_pin_out_d = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sel_q <= CLKSEL_DIRECT;
      crystal_pin_q <= 1'b0;
      flash_q <= 1'b0;
      pll_q <= PLL_EN_RESET;
      src_q <= CLK_SRC_RESET;
      clock_source_pin_en_q <= 1'b1;
      crystal_pin_oe_b_q <= 1'b1;
      crystal_pin_out_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      crystal_pin_q <= crystal_pin_d;
      flash_q <= flash_d;
      pll_q <= pll_d;
      src_q <= src_d;
      clock_source_pin_en_q <= clock_source_pin_en_d;
      crystal_pin_oe_b_q <= crystal_pin_oe_b_d;
      crystal_pin_out_q <= crystal_pin_out_d;
    end
  end

  // ==========================================================
  // clock output mirror
  logic clk_mirror_q;

  always_ff @(posedge CLK_INTERNAL or negedge CLK_INTERNAL)
  begin
    clk_mirror_q <= CLK_INTERNAL;
  end

  assign CRYSTAL_PIN_OUT = crystal_pin_out_q;
  assign CRYSTAL_PIN_OE_B = crystal_pin_oe_b_q;
  assign RESET_INDICATION_OUTPUT_B = rst_out_b_q;
  assign SYSTEM_RESET_B = sys_rst_b_q;
  assign PLL_ENABLE = pll_q;
  assign CLOCK_SOURCE = src_q;
  assign CLOCK_SOURCE_PIN_EN = clock_source_pin_en_q;
  assign FLASH_PROG_MODE = flash_q;
  assign SYSTEM_CLOCK_OUTPUT = clk_mirror_q;

endmodule

/* core/boot_cfg_pkg.sv */
package boot_cfg_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_MIN_CYCLES = 8;
  localparam int RESET_OUT_HOLD_CYCLES = 1024;
  localparam int RST_CNT_W = 4;
  localparam int HOLD_CNT_W = 11;

  // ==========================================================
  // clock boot select encodings
  localparam logic [1:0] CLKSEL_DIRECT = 2'h0;
  localparam logic [1:0] CLKSEL_CRYSTAL_PIN = 2'h1;
  localparam logic [1:0] CLKSEL_PLL = 2'h2;
  localparam logic [1:0] CLKSEL_PLL_CRYSTAL_PIN = 2'h3;
  localparam int CLKSEL_PLL_BIT = 1;

  // clock source selection codes
  typedef enum logic [1:0] {
    SRC_EXT_OSC = 2'h0,
    SRC_ON_CHIP = 2'h1,
    SRC_CRYSTAL = 2'h2
  } clk_src_e;

  // values held during reset
  localparam logic [1:0] CLK_SRC_RESET = 2'h0;
  localparam logic PLL_EN_RESET = 1'b0;

endpackage

/* core/reset_stretch.sv */
`timescale 1ns/1ps
module reset_stretch
  import boot_cfg_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_OUT_HOLD_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic src_active,
  output logic out_low
);

  logic [HOLD_CNT_W-1:0] cnt_q;
  logic [HOLD_CNT_W-1:0] cnt_d;
  logic low_q;
  logic low_d;

  // ==========================================================
  // hold output low for a fixed count after source release
  always_comb
  begin
    cnt_d = cnt_q;
    low_d = low_q;
    if (src_active)
    begin
      cnt_d = '0;
      low_d = 1'b1;
    end
    else if (low_q)
    begin
      if (cnt_q == HOLD_CNT_W'(HOLD_CYCLES - 1))
      begin
        low_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q + HOLD_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      low_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  assign out_low = low_q;

endmodule

/* bench/boot_reset_ctrl_props.sv */
`timescale 1ns/1ps
module boot_props
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic EXTERNAL_RESET_INPUT_B,
  input wire logic [1:0] CLOCK_BOOT_SELECT,
  input wire logic CRYSTAL_PIN_IN,
  input wire logic FLASH_BOOT_STRAP_B,
  input wire logic TEST_PIN,
  input wire logic CRYSTAL_PIN_OE_B,
  input wire logic RESET_INDICATION_OUTPUT_B,
  input wire logic SYSTEM_RESET_B,
  input wire logic PLL_ENABLE,
  input wire logic [1:0] CLOCK_SOURCE,
  input wire logic CLOCK_SOURCE_PIN_EN,
  input wire logic FLASH_PROG_MODE
);
  wire r = RESET_INDICATION_OUTPUT_B;
  wire [1:0] s = CLOCK_BOOT_SELECT;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  a_pll_mode: assert property ($rose(r) |-> PLL_ENABLE == $past(s[1]))
    else $error("bad pll");
  a_src_crystal_pin: assert property ($rose(r) && $past(s[0]) |-> CLOCK_SOURCE == 2'h2)
    else $error("bad source");
  a_src_pin: assert property ($rose(r) && !$past(s[0])
    |-> CLOCK_SOURCE == {1'b0, $past(CRYSTAL_PIN_IN)})
    else $error("bad source");
  a_crystal_pin_dir: assert property ($rose(r) |-> CRYSTAL_PIN_OE_B == $past(s[1]))
    else $error("bad pin dir");
  a_pin_use: assert property (CLOCK_SOURCE_PIN_EN == (CLOCK_SOURCE != 2'h1))
    else $error("bad pin use");
  a_flash_mode: assert property ($rose(r)
    |-> FLASH_PROG_MODE == (!$past(FLASH_BOOT_STRAP_B) && !$past(TEST_PIN)))
    else $error("bad flash");
  a_cfg_hold: assert property (SYSTEM_RESET_B && $past(SYSTEM_RESET_B)
    |-> $stable({CLOCK_SOURCE, PLL_ENABLE, FLASH_PROG_MODE, CRYSTAL_PIN_OE_B}))
    else $error("config moved");
  a_ext_min: assert property (!EXTERNAL_RESET_INPUT_B [*8] |-> ##2 !SYSTEM_RESET_B)
    else $error("no reset");
  c_boot: cover property ($rose(r));
  c_flash: cover property ($rose(FLASH_PROG_MODE));
  c_ext: cover property ($fell(SYSTEM_RESET_B));
  c_onchip: cover property ($rose(r) && CLOCK_SOURCE == 2'h1);
endmodule

bind boot_reset_ctrl boot_props boot_props_inst (.*);

/* bench/board_model.sv */
`timescale 1ns/1ps
module board_model
(
  input wire logic clk,
  input wire logic crystal_pin_out,
  input wire logic crystal_pin_oe_b,
  output logic ext_rst_b,
  output logic [1:0] sel,
  output logic crystal_pin_in,
  output logic strap_b,
  output logic test
);
  logic crystal_pin_drv;
  assign crystal_pin_in = crystal_pin_oe_b ? crystal_pin_drv : crystal_pin_out;
  initial {ext_rst_b, sel, crystal_pin_drv, strap_b, test} = 6'h22;
  task straps(input logic [4:0] v);
    {sel, crystal_pin_drv, strap_b, test} = v;
  endtask
  task pulse(input int n);
    ext_rst_b = 1'b0;
    repeat (n) @(negedge clk);
    ext_rst_b = 1'b1;
  endtask
endmodule

/* bench/reset_and_boot_clock_mode_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("unexpected %0t %h %h", $time, a, b); end end
module reset_and_boot_clock_mode_tb_top;
  localparam int HOLD = 16;
  logic CLK_SYS = 1'b0, RST_B = 1'b0, EXTERNAL_RESET_INPUT_B, CRYSTAL_PIN_IN, FLASH_BOOT_STRAP_B, TEST_PIN;
  logic [1:0] CLOCK_BOOT_SELECT;
  wire [1:0] CLOCK_SOURCE;
  wire CRYSTAL_PIN_OUT, CRYSTAL_PIN_OE_B, RESET_INDICATION_OUTPUT_B, SYSTEM_RESET_B, PLL_ENABLE;
  wire CLOCK_SOURCE_PIN_EN, FLASH_PROG_MODE, SYSTEM_CLOCK_OUTPUT, CLK_INTERNAL = CLK_SYS;
  int failures = 0, compares = 0, cycles = 0;
  logic [4:0] modes [7] = '{5'h02, 5'h06, 5'h08, 5'h12, 5'h16, 5'h19, 5'h1E};
  boot_reset_ctrl #(.HOLD_CYCLES(HOLD)) boot_reset_ctrl_inst (.*);
  board_model board_model_inst (.clk(CLK_SYS), .crystal_pin_out(CRYSTAL_PIN_OUT), .crystal_pin_oe_b(CRYSTAL_PIN_OE_B),
    .ext_rst_b(EXTERNAL_RESET_INPUT_B), .sel(CLOCK_BOOT_SELECT), .crystal_pin_in(CRYSTAL_PIN_IN),
    .strap_b(FLASH_BOOT_STRAP_B), .test(TEST_PIN));
  initial forever #2.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == 1500)
    begin
      failures++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task boot(input logic [4:0] v);
    logic [1:0] src;
    logic fl;
    src = v[3] ? 2'h2 : {1'b0, v[2]};
    fl = !v[1] && !v[0];
    board_model_inst.straps(v);
    RST_B = 1'b0;
    repeat (10) @(negedge CLK_SYS);
    RST_B = 1'b1;
    repeat (HOLD) @(negedge CLK_SYS);
    `CHK({RESET_INDICATION_OUTPUT_B, CRYSTAL_PIN_OE_B}, 2'h1)
    @(negedge CLK_SYS);
    `CHK({RESET_INDICATION_OUTPUT_B, SYSTEM_RESET_B, PLL_ENABLE, CLOCK_SOURCE}, {2'h3, v[4], src})
    `CHK({CLOCK_SOURCE_PIN_EN, CRYSTAL_PIN_OE_B, FLASH_PROG_MODE}, {src != 2'h1, v[4], fl})
    board_model_inst.straps(~v);
    repeat (3) @(negedge CLK_SYS);
    `CHK({PLL_ENABLE, CLOCK_SOURCE, FLASH_PROG_MODE}, {v[4], src, fl})
  endtask
  task ext(input int n);
    board_model_inst.pulse(n);
    repeat (3) @(negedge CLK_SYS);
    `CHK({SYSTEM_RESET_B, RESET_INDICATION_OUTPUT_B}, n < 8 ? 2'h3 : 2'h0)
    repeat (HOLD - 2) @(negedge CLK_SYS);
    `CHK(RESET_INDICATION_OUTPUT_B, n < 8)
    @(negedge CLK_SYS);
    `CHK(RESET_INDICATION_OUTPUT_B, 1'b1)
  endtask
  task clk_out();
    @(posedge CLK_SYS);
    #1;
    `CHK(SYSTEM_CLOCK_OUTPUT, 1'b1)
    @(negedge CLK_SYS);
    #1;
    `CHK(SYSTEM_CLOCK_OUTPUT, 1'b0)
    `CHK(CRYSTAL_PIN_OUT, 1'b0)
  endtask
  initial
  begin
    foreach (modes[i])
      boot(modes[i]);
    ext(7);
    ext(8);
    clk_out();
    report_and_stop();
  end
endmodule
